// >>> src/link_err_map.vh
// register indices, field positions and reset values of the link error aggregator
`ifndef LINK_ERR_MAP_VH
`define LINK_ERR_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define IDX_PIPE_OEN     30'h0000_0049
`define IDX_PIPE_FLAGS   30'h0000_004a
`define IDX_PIPE_LCLR    30'h0000_08c7
`define IDX_PIPE0_STAT   30'h0000_0934
`define IDX_PIPE1_STAT   30'h0000_0974
`define IDX_PIPE2_STAT   30'h0000_09b4
`define IDX_PIPE3_STAT   30'h0000_09f4
`define IDX_ERR_OEN      30'h0000_0100
`define IDX_ERR_FLAGS    30'h0000_0101
`define IDX_CTRL         30'h0000_0102
`define IDX_PIX_CNT      30'h0000_0103
`define IDX_PRBS_CNT     30'h0000_0104
`define IDX_FS_CNT       30'h0000_0105
`define IDX_FS_LIMIT     30'h0000_0106
`define IDX_UNC_CNT      30'h0000_0107
`define IDX_COR_CNT      30'h0000_0108
`define IDX_UNC_LIMIT    30'h0000_0109
`define IDX_COR_LIMIT    30'h0000_010a
`define IDX_STATS_CLR    30'h0000_010b
`define IDX_ADC_SRC      30'h0000_010c

// ----------------------------------------------------------------
// source bit positions in the enable and flag registers
// ----------------------------------------------------------------
`define SRC_REMOTE       0
`define SRC_LINE         1
`define SRC_PIXEL        2
`define SRC_SEQ          3
`define SRC_BLK          4
`define SRC_PRBS         5
`define SRC_FSYNC        6
`define SRC_FEC          7
`define SRC_ADC          8
`define SRC_VDDCMP       9
`define SRC_BROWNOUT     10
`define SRC_NUM          11

// ----------------------------------------------------------------
// control bits and clear bits
// ----------------------------------------------------------------
`define CTRL_LINE_EN     0
`define CTRL_PIX_EN      1
`define CTRL_PRBS_EN     2
`define CLR_ALL          0
`define CLR_UNC          1
`define CLR_COR          2
`define STAT_NOW         0
`define STAT_LATCHED     1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_ERR_OEN      11'h7ff
`define RST_PIPE_OEN     4'h0
`define RST_CTRL         3'h1
`define RST_FS_LIMIT     8'h00
`define RST_UNC_LIMIT    16'h0000
`define RST_COR_LIMIT    16'h0000

`endif

// >>> src/link_error_flag_aggregator.v
// error flag collection, read-clear logic, ahb-lite register slave and error pin driver
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "link_err_map.vh"

// Contract
// [RULE1] mirror remote error status only while locked
// [RULE2] remote flag ignores reads, follows remote
// [RULE3] line check on by default, mismatch sets flag
// [RULE4] line flag latches; read or relock clears
// [RULE5] pixel check off by default, software enables
// [RULE6] pixel flag while pixel count above zero
// [RULE7] pixel count clears on read/auto/relock
// [RULE8] sequence gap flag latches, read clears
// [RULE9] block size flag latches, read clears
// [RULE10] per-pipe mask flag while pipe blanked
// [RULE11] blank status: now plus latched, write clears
// [RULE12] per-pipe mask enables onto error pin
// [RULE13] pattern test flag on errors; read clears
// [RULE14] count frame misalignments, flag above limit
// [RULE15] frame count read clears count and flag
// [RULE16] correction flag when either count exceeds limit
// [RULE17] software writes one to clear correction stats
// [RULE18] converter flag while any latched source set
// [RULE19] supply compare flag latches, read clears
// [RULE20] brownout flag latches, read clears
// [RULE21] error pin low while enabled error active
// [RULE22] pin is or of flags gated by enables
module link_error_flag_aggregator (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg  [31:0] hrdata,
	output reg         hresp,
	input  wire        link_locked,
	input  wire        remote_err_status,
	input  wire        line_crc_mismatch,
	input  wire        pixel_crc_mismatch,
	input  wire        seq_gap_event,
	input  wire        block_size_event,
	input  wire [3:0]  pipe_masked,
	input  wire        prbs_bit_error,
	input  wire        vsync_misalign,
	input  wire        fec_uncorr_block,
	input  wire        fec_corr_bit,
	input  wire [3:0]  adc_limit_hit,
	input  wire        auto_err_reset,
	input  wire        supply_cmp_low,
	input  wire        supply_brownout,
	output reg         error_out_n
);

	// ----------------------------------------------------------------
	// bus front end
	// ----------------------------------------------------------------
	reg  [29:0] wr_idx_q;
	reg         wr_pend_q;
	reg  [29:0] rd_idx_q;
	reg         rd_pend_q;
	wire        take;
	wire        wr_fire;
	wire        rd_fire;

	// reads take one wait state so a write just before is already stored
	assign take    = hsel & htrans[1] & hready;
	assign wr_fire = wr_pend_q;
	assign rd_fire = rd_pend_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_idx_q  <= 30'h0000_0000;
			wr_pend_q <= 1'b0;
			rd_idx_q  <= 30'h0000_0000;
			rd_pend_q <= 1'b0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hresp     <= 1'b0;
			wr_pend_q <= take & hwrite;
			if (take) begin
				wr_idx_q <= haddr[31:2];
				rd_idx_q <= haddr[31:2];
			end
			rd_pend_q <= take & ~hwrite;
			hreadyout <= ~(take & ~hwrite);
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisers for the analog comparators
	// ----------------------------------------------------------------
	reg  [1:0] sync1_q;
	reg  [1:0] sync2_q;
	reg  [1:0] sync3_q;
	reg  [1:0] cmp_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
			sync3_q <= 2'h0;
			cmp_q   <= 2'h0;
		end else begin
			sync1_q <= {supply_brownout, supply_cmp_low};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			cmp_q   <= (sync2_q & sync3_q) | (cmp_q & (sync2_q | sync3_q));
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	reg  [10:0] err_oen_q;
	reg  [3:0]  pipe_oen_q;
	reg  [2:0]  ctrl_q;
	reg  [7:0]  fs_limit_q;
	reg  [15:0] unc_limit_q;
	reg  [15:0] cor_limit_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_oen_q   <= `RST_ERR_OEN;
			pipe_oen_q  <= `RST_PIPE_OEN;
			ctrl_q      <= `RST_CTRL; // [RULE3] [RULE5]
			fs_limit_q  <= `RST_FS_LIMIT;
			unc_limit_q <= `RST_UNC_LIMIT;
			cor_limit_q <= `RST_COR_LIMIT;
		end else if (wr_fire) begin
			case (wr_idx_q)
				`IDX_ERR_OEN:   err_oen_q   <= hwdata[10:0];
				`IDX_PIPE_OEN:  pipe_oen_q  <= hwdata[3:0]; // [RULE12]
				`IDX_CTRL:      ctrl_q      <= hwdata[2:0]; // [RULE5]
				`IDX_FS_LIMIT:  fs_limit_q  <= hwdata[7:0];
				`IDX_UNC_LIMIT: unc_limit_q <= hwdata[15:0];
				`IDX_COR_LIMIT: cor_limit_q <= hwdata[15:0];
				default:        ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// clear strobes
	// ----------------------------------------------------------------
	reg         lock_q;
	wire        relock;
	wire        rd_flags;
	wire        rd_pix;
	wire        rd_prbs;
	wire        rd_fs;
	wire        rd_adc;
	wire [3:0]  lclr;
	wire        clr_unc;
	wire        clr_cor;

	assign relock   = link_locked & ~lock_q;
	assign rd_flags = rd_fire & (rd_idx_q == `IDX_ERR_FLAGS);
	assign rd_pix   = rd_fire & (rd_idx_q == `IDX_PIX_CNT);
	assign rd_prbs  = rd_fire & (rd_idx_q == `IDX_PRBS_CNT);
	assign rd_fs    = rd_fire & (rd_idx_q == `IDX_FS_CNT);
	assign rd_adc   = rd_fire & (rd_idx_q == `IDX_ADC_SRC);
	assign lclr     = (wr_fire && wr_idx_q == `IDX_PIPE_LCLR) ? hwdata[3:0] : 4'h0; // [RULE11]
	assign clr_unc  = wr_fire && wr_idx_q == `IDX_STATS_CLR && (hwdata[`CLR_ALL] | hwdata[`CLR_UNC]); // [RULE17]
	assign clr_cor  = wr_fire && wr_idx_q == `IDX_STATS_CLR && (hwdata[`CLR_ALL] | hwdata[`CLR_COR]); // [RULE17]

	// ----------------------------------------------------------------
	// flags and counters; an event in the clearing cycle survives
	// ----------------------------------------------------------------
	reg         remote_q;
	reg         line_q;
	reg  [7:0]  pix_cnt_q;
	reg         seq_q;
	reg         blk_q;
	reg  [7:0]  prbs_cnt_q;
	reg  [7:0]  fs_cnt_q;
	reg  [15:0] unc_cnt_q;
	reg  [15:0] cor_cnt_q;
	reg  [3:0]  adc_src_q;
	reg         vddcmp_q;
	reg         brown_q;
	reg  [3:0]  mask_lat_q;
	wire        pix_inc;
	wire        prbs_inc;

	assign pix_inc  = pixel_crc_mismatch & ctrl_q[`CTRL_PIX_EN];
	assign prbs_inc = prbs_bit_error & ctrl_q[`CTRL_PRBS_EN];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_q     <= 1'b0;
			remote_q   <= 1'b0;
			line_q     <= 1'b0;
			pix_cnt_q  <= 8'h00;
			seq_q      <= 1'b0;
			blk_q      <= 1'b0;
			prbs_cnt_q <= 8'h00;
			fs_cnt_q   <= 8'h00;
			unc_cnt_q  <= 16'h0000;
			cor_cnt_q  <= 16'h0000;
			adc_src_q  <= 4'h0;
			vddcmp_q   <= 1'b0;
			brown_q    <= 1'b0;
			mask_lat_q <= 4'h0;
		end else begin
			lock_q   <= link_locked;
			remote_q <= link_locked & remote_err_status; // [RULE1] [RULE2]
			line_q   <= (line_crc_mismatch & ctrl_q[`CTRL_LINE_EN]) |
			            (line_q & ~rd_flags & ~relock); // [RULE3] [RULE4]
			// counters saturate rather than wrap so a flag never drops by itself
			if (rd_pix | auto_err_reset | relock)
				pix_cnt_q <= {7'h00, pix_inc}; // [RULE7]
			else if (pix_inc && pix_cnt_q != 8'hff)
				pix_cnt_q <= pix_cnt_q + 8'h01;
			seq_q <= seq_gap_event | (seq_q & ~rd_flags); // [RULE8]
			blk_q <= block_size_event | (blk_q & ~rd_flags); // [RULE9]
			if (rd_prbs)
				prbs_cnt_q <= {7'h00, prbs_inc}; // [RULE13]
			else if (prbs_inc && prbs_cnt_q != 8'hff)
				prbs_cnt_q <= prbs_cnt_q + 8'h01;
			if (rd_fs)
				fs_cnt_q <= {7'h00, vsync_misalign}; // [RULE15]
			else if (vsync_misalign && fs_cnt_q != 8'hff)
				fs_cnt_q <= fs_cnt_q + 8'h01; // [RULE14]
			if (clr_unc)
				unc_cnt_q <= {15'h0000, fec_uncorr_block};
			else if (fec_uncorr_block && unc_cnt_q != 16'hffff)
				unc_cnt_q <= unc_cnt_q + 16'h0001;
			if (clr_cor)
				cor_cnt_q <= {15'h0000, fec_corr_bit};
			else if (fec_corr_bit && cor_cnt_q != 16'hffff)
				cor_cnt_q <= cor_cnt_q + 16'h0001;
			adc_src_q  <= adc_limit_hit | (adc_src_q & {4{~rd_adc}}); // [RULE18]
			vddcmp_q   <= cmp_q[0] | (vddcmp_q & ~rd_flags); // [RULE19]
			brown_q    <= cmp_q[1] | (brown_q & ~rd_flags); // [RULE20]
			mask_lat_q <= pipe_masked | (mask_lat_q & ~lclr); // [RULE11]
		end
	end

	// ----------------------------------------------------------------
	// flag vector and error pin
	// ----------------------------------------------------------------
	wire [10:0] flags;

	assign flags[`SRC_REMOTE]   = remote_q;
	assign flags[`SRC_LINE]     = line_q;
	assign flags[`SRC_PIXEL]    = pix_cnt_q != 8'h00; // [RULE6]
	assign flags[`SRC_SEQ]      = seq_q;
	assign flags[`SRC_BLK]      = blk_q;
	assign flags[`SRC_PRBS]     = prbs_cnt_q != 8'h00; // [RULE13]
	assign flags[`SRC_FSYNC]    = fs_cnt_q > fs_limit_q; // [RULE14]
	assign flags[`SRC_FEC]      = (unc_cnt_q > unc_limit_q) | (cor_cnt_q > cor_limit_q); // [RULE16]
	assign flags[`SRC_ADC]      = |adc_src_q; // [RULE18]
	assign flags[`SRC_VDDCMP]   = vddcmp_q;
	assign flags[`SRC_BROWNOUT] = brown_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			error_out_n <= 1'b1;
		else
			error_out_n <= ~(|(flags & err_oen_q) | |(pipe_masked & pipe_oen_q)); // [RULE10] [RULE12] [RULE21] [RULE22]
	end

	// ----------------------------------------------------------------
	// read data; unmapped words read zero
	// ----------------------------------------------------------------
	reg  [31:0] rmux;

	always @* begin
		rmux = 32'h0000_0000;
		case (rd_idx_q)
			`IDX_PIPE_OEN:   rmux[3:0]   = pipe_oen_q;
			`IDX_PIPE_FLAGS: rmux[3:0]   = pipe_masked; // [RULE10]
			`IDX_PIPE0_STAT: rmux[1:0]   = {mask_lat_q[0], pipe_masked[0]};
			`IDX_PIPE1_STAT: rmux[1:0]   = {mask_lat_q[1], pipe_masked[1]};
			`IDX_PIPE2_STAT: rmux[1:0]   = {mask_lat_q[2], pipe_masked[2]};
			`IDX_PIPE3_STAT: rmux[1:0]   = {mask_lat_q[3], pipe_masked[3]};
			`IDX_ERR_OEN:    rmux[10:0]  = err_oen_q;
			`IDX_ERR_FLAGS:  rmux[10:0]  = flags;
			`IDX_CTRL:       rmux[2:0]   = ctrl_q;
			`IDX_PIX_CNT:    rmux[7:0]   = pix_cnt_q;
			`IDX_PRBS_CNT:   rmux[7:0]   = prbs_cnt_q;
			`IDX_FS_CNT:     rmux[7:0]   = fs_cnt_q;
			`IDX_FS_LIMIT:   rmux[7:0]   = fs_limit_q;
			`IDX_UNC_CNT:    rmux[15:0]  = unc_cnt_q;
			`IDX_COR_CNT:    rmux[15:0]  = cor_cnt_q;
			`IDX_UNC_LIMIT:  rmux[15:0]  = unc_limit_q;
			`IDX_COR_LIMIT:  rmux[15:0]  = cor_limit_q;
			`IDX_ADC_SRC:    rmux[3:0]   = adc_src_q;
			default:         rmux        = 32'h0000_0000;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (rd_fire)
			hrdata <= rmux;
	end

endmodule

// >>> sim/link_error_flag_aggregator_props.sv
// port-level assertion checker for the link error aggregator
`timescale 1ns/100ps
`include "link_err_map.vh"
module link_error_flag_aggregator_props (
	input  logic        hclk,
	input  logic        hresetn,
	input  logic        hsel,
	input  logic [31:0] haddr,
	input  logic [1:0]  htrans,
	input  logic        hwrite,
	input  logic [31:0] hwdata,
	input  logic        hready,
	input  logic        hreadyout,
	input  logic        hresp,
	input  logic        link_locked,
	input  logic        remote_err_status,
	input  logic        line_crc_mismatch,
	input  logic        seq_gap_event,
	input  logic        block_size_event,
	input  logic [3:0]  pipe_masked,
	input  logic        error_out_n
);
	logic        wr_q;
	logic [29:0] adr_q;
	logic [10:0] oen_q;
	logic [3:0]  poen_q;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ----------------------------------------------------------------
	// shadow of the enables, so pin checks know what is routed
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q   <= 1'b0;
			adr_q  <= 30'h0;
			oen_q  <= `RST_ERR_OEN;
			poen_q <= `RST_PIPE_OEN;
		end else begin
			if (wr_q && adr_q == `IDX_ERR_OEN)
				oen_q <= hwdata[10:0];
			if (wr_q && adr_q == `IDX_PIPE_OEN)
				poen_q <= hwdata[3:0];
			if (hready) begin
				wr_q  <= hsel & htrans[1] & hwrite;
				adr_q <= haddr[31:2];
			end
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_rd_wait;
		hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	property p_wr_nowait;
		hsel && htrans[1] && hready && hwrite |=> hreadyout;
	endproperty
	a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
	property p_okay;
		!hresp;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_remote;
		link_locked && remote_err_status && oen_q[0] |-> ##2 !error_out_n;
	endproperty
	a_remote: assert property (p_remote) else $error("remote fault not on pin");
	property p_line;
		line_crc_mismatch && oen_q[1] |-> ##2 !error_out_n;
	endproperty
	a_line: assert property (p_line) else $error("line fault not on pin");
	property p_seq;
		seq_gap_event && oen_q[3] |-> ##2 !error_out_n [*2];
	endproperty
	a_seq: assert property (p_seq) else $error("sequence flag not held");
	property p_blk;
		block_size_event && oen_q[4] |-> ##2 !error_out_n [*2];
	endproperty
	a_blk: assert property (p_blk) else $error("block flag not held");
	property p_pipe;
		|(pipe_masked & poen_q) |=> !error_out_n;
	endproperty
	a_pipe: assert property (p_pipe) else $error("masked pipe not on pin");
	property p_mute;
		oen_q == 11'h000 && poen_q == 4'h0 |=> error_out_n;
	endproperty
	a_mute: assert property (p_mute) else $error("pin low with all enables off");
endmodule

bind link_error_flag_aggregator link_error_flag_aggregator_props u_props (.*);

// >>> sim/host_model.sv
// ahb-lite host controller model issuing single word transfers
`timescale 1ns/100ps
module host_model (
	input  logic        hclk,
	input  logic        hreadyout,
	input  logic [31:0] hrdata,
	output logic        hsel,
	output logic [31:0] haddr,
	output logic [1:0]  htrans,
	output logic        hwrite,
	output logic [2:0]  hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// called right after a rising edge; returns at the edge that took the data
	task automatic xfer(input logic w, input logic [29:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {idx, 2'b00};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		haddr <= ~haddr;
		hwdata <= w ? wd : ~hwdata;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
endmodule

// >>> sim/link_error_flag_aggregator_test.sv
// self-checking bench for the link error aggregator
`timescale 1ns/100ps
`include "link_err_map.vh"
module link_error_flag_aggregator_test;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic        hwrite;
	logic        hreadyout;
	logic        hresp;
	logic        error_out_n;
	logic        link_locked;
	logic        remote_err_status;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [10:0] ev;
	logic [3:0]  pipe_masked;
	logic [3:0]  adc_limit_hit;
	int          n_fail;
	int          checks;
	int          n;
	int          m;

	link_error_flag_aggregator u_link_error_flag_aggregator (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link_locked(link_locked),
		.remote_err_status(remote_err_status), .line_crc_mismatch(ev[0]),
		.pixel_crc_mismatch(ev[1]), .seq_gap_event(ev[2]), .block_size_event(ev[3]),
		.pipe_masked(pipe_masked), .prbs_bit_error(ev[4]), .vsync_misalign(ev[5]),
		.fec_uncorr_block(ev[6]), .fec_corr_bit(ev[7]), .adc_limit_hit(adc_limit_hit),
		.auto_err_reset(ev[8]), .supply_cmp_low(ev[9]), .supply_brownout(ev[10]),
		.error_out_n(error_out_n));
	host_model u_host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic w(input int k);
		repeat (k) @(posedge hclk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [29:0] idx, input logic [31:0] exp);
		u_host.xfer(1'b0, idx, 32'h0, rd);
		chk(rd, exp);
	endtask
	task automatic wr(input logic [29:0] idx, input logic [31:0] d);
		u_host.xfer(1'b1, idx, d, rd);
	endtask
	// slack after the pulses covers the comparator synchronisers;
	// comparator pins are held three cycles high; two cycles are enough for two sync stages to agree
	task automatic pulse(input int b, input int k);
		repeat (k) begin
			ev[b] <= 1'b1;
			w(b >= 9 ? 3 : 1);
			ev[b] <= 1'b0;
			w(1);
		end
		w(8);
	endtask
	task automatic summarize;
		if (n_fail == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		repeat (20000) @(posedge hclk);
		n_fail++;
		summarize();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int          sb[5] = '{1, 3, 4, 9, 10};
		int          eb[5] = '{0, 2, 3, 9, 10};
		logic [29:0] ps[4] = '{`IDX_PIPE0_STAT, `IDX_PIPE1_STAT, `IDX_PIPE2_STAT, `IDX_PIPE3_STAT};
		n_fail = 0;
		checks = 0;
		hresetn = 1'b0;
		ev = '0;
		link_locked = 1'b0;
		remote_err_status = 1'b0;
		pipe_masked = 4'h0;
		adc_limit_hit = 4'h0;
		void'($urandom(32'hd603));
		w(6);
		hresetn <= 1'b1;
		w(1);
		chk(error_out_n, 1'b1);
		rdc(`IDX_ERR_OEN, 32'h7ff);
		rdc(`IDX_CTRL, 32'h1);
		rdc(`IDX_PIPE_OEN, 32'h0);
		pulse(2, 1);
		wr(`IDX_ERR_OEN, 32'h0);
		w(2);
		chk(error_out_n, 1'b1);
		wr(`IDX_ERR_OEN, 32'h7ff);
		rdc(`IDX_ERR_FLAGS, 32'h8);
		for (int i = 0; i < 5; i++) begin
			pulse(eb[i], 1);
			chk(error_out_n, 1'b0);
			rdc(`IDX_ERR_FLAGS, 32'h1 << sb[i]);
			rdc(`IDX_ERR_FLAGS, 32'h0);
		end
		w(2);
		chk(error_out_n, 1'b1);
		remote_err_status <= 1'b1;
		w(4);
		rdc(`IDX_ERR_FLAGS, 32'h0);
		link_locked <= 1'b1;
		w(4);
		rdc(`IDX_ERR_FLAGS, 32'h1);
		rdc(`IDX_ERR_FLAGS, 32'h1);
		pulse(0, 1);
		link_locked <= 1'b0;
		w(4);
		link_locked <= 1'b1;
		w(4);
		rdc(`IDX_ERR_FLAGS, 32'h1);
		remote_err_status <= 1'b0;
		w(4);
		rdc(`IDX_ERR_FLAGS, 32'h0);
		pulse(1, 1);
		rdc(`IDX_PIX_CNT, 32'h0);
		wr(`IDX_CTRL, 32'h7);
		n = $urandom_range(6, 1);
		pulse(1, n);
		rdc(`IDX_ERR_FLAGS, 32'h4);
		rdc(`IDX_PIX_CNT, n);
		rdc(`IDX_ERR_FLAGS, 32'h0);
		pulse(4, n);
		rdc(`IDX_ERR_FLAGS, 32'h20);
		rdc(`IDX_PRBS_CNT, n);
		rdc(`IDX_ERR_FLAGS, 32'h0);
		pulse(1, 2);
		pulse(8, 1);
		rdc(`IDX_PIX_CNT, 32'h0);
		wr(`IDX_FS_LIMIT, 32'h2);
		pulse(5, 2);
		rdc(`IDX_ERR_FLAGS, 32'h0);
		pulse(5, 1);
		rdc(`IDX_ERR_FLAGS, 32'h40);
		rdc(`IDX_FS_CNT, 32'h3);
		rdc(`IDX_ERR_FLAGS, 32'h0);
		wr(`IDX_COR_LIMIT, 32'h1);
		pulse(7, 1);
		rdc(`IDX_ERR_FLAGS, 32'h0);
		pulse(7, 1);
		rdc(`IDX_ERR_FLAGS, 32'h80);
		rdc(`IDX_COR_CNT, 32'h2);
		wr(`IDX_STATS_CLR, 32'h4);
		rdc(`IDX_ERR_FLAGS, 32'h0);
		pulse(6, 1);
		rdc(`IDX_ERR_FLAGS, 32'h80);
		wr(`IDX_STATS_CLR, 32'h2);
		rdc(`IDX_UNC_CNT, 32'h0);
		pulse(6, 1);
		pulse(7, 2);
		wr(`IDX_STATS_CLR, 32'h1);
		rdc(`IDX_COR_CNT, 32'h0);
		rdc(`IDX_ERR_FLAGS, 32'h0);
		m = $urandom_range(15, 1);
		adc_limit_hit <= m[3:0];
		w(2);
		adc_limit_hit <= 4'h0;
		w(3);
		rdc(`IDX_ERR_FLAGS, 32'h100);
		rdc(`IDX_ADC_SRC, m);
		rdc(`IDX_ERR_FLAGS, 32'h0);
		n = $urandom_range(15, 1);
		wr(`IDX_PIPE_OEN, n);
		pipe_masked <= m[3:0];
		w(2);
		chk(error_out_n, (m & n) == 0);
		rdc(`IDX_PIPE_FLAGS, m);
		pipe_masked <= 4'h0;
		w(2);
		for (int p = 0; p < 4; p++)
			rdc(ps[p], m[p] ? 32'h2 : 32'h0);
		wr(`IDX_PIPE_LCLR, 32'hf);
		for (int p = 0; p < 4; p++)
			rdc(ps[p], 32'h0);
		wr(30'h200, 32'hffff_ffff);
		rdc(30'h200, 32'h0);
		summarize();
	end
endmodule
